// >>> logic/hioc_cmd_handler.sv
// The AHB-Lite register port and the register offsets were decided locally.
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// RULE1 - code 13: start, stop, query homing
// RULE2 - homing query: zero idle, nonzero active
// RULE3 - homing start/stop reply status 100
// RULE4 - code 14 bank 2 sets one output
// RULE5 - port 255 bank 2 sets all outputs
// RULE6 - value -1 takes outputs from accumulator
// RULE7 - port 0 bank 0 switches pull-ups
// RULE8 - code 15 reads line, status 100
// RULE9 - digital reads 0/1, ADC 0..4095
// RULE10 - standalone mode: read loads accumulator
// RULE11 - direct mode: accumulator left unchanged; the code still loads it on the port 255 bank 0 read
// RULE12 - bank 0 returns inputs 0..3
// RULE13 - analog lines readable digitally too; ADC0 is read here only as a 12-bit count in bank 1
// RULE14 - port 255 bank 0 loads accumulator
// RULE15 - port 11 bank 0 encoder-zero flag
// RULE16 - bank 1: ADC, voltage, temperature
// RULE17 - output states readable by host
// RULE18 - bank 2 read returns set outputs
// RULE19 - fixed nine-byte command and reply frames
// RULE20 - checksum is modulo-256 byte sum
module hioc_cmd_handler
    import hioc_pkg::*;
#(
    parameter int NOUT = 2,
    parameter int NIN  = 4
) (
    // clock and reset
    input  wire logic            clk,
    input  wire logic            rst_n,
    // AHB-Lite slave
    input  wire logic            hsel,
    input  wire logic [7:0]      haddr,
    input  wire logic [1:0]      htrans,
    input  wire logic            hwrite,
    input  wire logic [2:0]      hsize,
    input  wire logic [31:0]     hwdata,
    input  wire logic            hready,
    output logic      [31:0]     hrdata,
    output logic                 hreadyout,
    output logic                 hresp,
    // general purpose pins
    input  wire logic [NIN-1:0]  gpInputPin,
    input  wire logic            encZeroPin,
    output logic      [NOUT-1:0] gpOutput_ff,
    output logic                 pullUpEn_ff,
    // analog values from converters (own clock domain)
    input  wire logic [11:0]     adcCount,
    input  wire logic [15:0]     supplyTenthV,
    input  wire logic [15:0]     tempDegC,
    // homing engine
    output logic                 homeStart_ff,
    output logic                 homeStop_ff
);
    ////////////////////////////////////////////////////////////////////////
    // synchronised pins
    logic [NIN-1:0] gpIn;
    logic [0:0]     encZero;
    hioc_sync #(.W(NIN)) uSyncIn (
        .clk  (clk),
        .rst_n(rst_n),
        .din  (gpInputPin),
        .dout (gpIn)
    );
    hioc_sync #(.W(1)) uSyncEnc (
        .clk  (clk),
        .rst_n(rst_n),
        .din  (encZeroPin),
        .dout (encZero)
    );

    ////////////////////////////////////////////////////////////////////////
    // bus state
    logic        aValid_ff, nxt_aValid;   // pending data phase
    logic        aWrite_ff, nxt_aWrite;   // pending write
    logic [7:0]  aAddr_ff,  nxt_aAddr;    // pending address
    logic [31:0] rdata_ff,  nxt_rdata;    // read data register
    // command machinery
    hioc_cmd_type cmd_ff, nxt_cmd;        // staged command frame
    hioc_rep_type rep_ff, nxt_rep;        // last reply frame
    logic        go_ff,    nxt_go;        // execute request
    logic        repNew_ff, nxt_repNew;   // reply not yet read
    logic        standalone_ff, nxt_standalone;
    logic [31:0] acc_ff,   nxt_acc;       // accumulator
    logic [7:0]  modAddr_ff, nxt_modAddr; // module address
    logic        homeBusy_ff, nxt_homeBusy;
    logic [NOUT-1:0] nxt_gpOut;
    logic        nxt_pullUp, nxt_hStart, nxt_hStop;
    logic [7:0]  cmdSum, repSum;
    hioc_rep_type repRaw;

    hioc_sum uSumCmd (
        .body(cmd_ff[71:8]),
        .sum (cmdSum)
    );
    hioc_sum uSumRep (
        .body(repRaw[71:8]),
        .sum (repSum)
    );

    ////////////////////////////////////////////////////////////////////////
    // command execution, combinational
    logic [7:0]  st;
    logic [31:0] rv;
    logic        accLoad;
    logic [31:0] accVal;
    logic        allBits;
    always_comb begin
        st        = ST_OK;
        rv        = 32'h0000_0000;
        accLoad   = 1'b0;
        accVal    = acc_ff;
        nxt_gpOut = gpOutput_ff;
        nxt_pullUp = pullUpEn_ff;
        nxt_hStart = 1'b0;
        nxt_hStop  = 1'b0;
        allBits    = 1'b0;
        if (cmd_ff.sum != cmdSum) begin
            st = ST_BADSUM; // [RULE20]
        end else begin
            unique case (cmd_ff.instr)
                INSTR_HOMING: begin // [RULE1]
                    if (cmd_ff.kind == HOME_START) begin
                        nxt_hStart = 1'b1; // [RULE3]
                    end else if (cmd_ff.kind == HOME_STOP) begin
                        nxt_hStop = 1'b1; // [RULE3]
                    end else if (cmd_ff.kind == HOME_STATUS) begin
                        rv = {31'h0, homeBusy_ff}; // [RULE2]
                    end else begin
                        st = ST_BADTYPE;
                    end
                end
                INSTR_OUTSET: begin
                    if (cmd_ff.bank == BANK_OUT
                        && cmd_ff.kind == PORT_ALL) begin
                        // whole vector, -1 means accumulator
                        allBits = 1'b1;
                        if (cmd_ff.value == VAL_FROM_ACC) begin
                            nxt_gpOut = acc_ff[NOUT-1:0]; // [RULE6]
                        end else if (cmd_ff.value[31:8] == 24'h0) begin
                            nxt_gpOut = cmd_ff.value[NOUT-1:0]; // [RULE5]
                        end else begin
                            st = ST_BADVAL;
                        end
                    end else if (cmd_ff.bank == BANK_OUT
                                 && cmd_ff.kind < 8'(NOUT)) begin
                        if (cmd_ff.value[31:1] == 31'h0) begin
                            nxt_gpOut[cmd_ff.kind[0]] =
                                cmd_ff.value[0]; // [RULE4]
                        end else begin
                            st = ST_BADVAL;
                        end
                    end else if (cmd_ff.bank == BANK_DIG
                                 && cmd_ff.kind == PORT_PULLUP) begin
                        if (cmd_ff.value[31:1] == 31'h0) begin
                            nxt_pullUp = cmd_ff.value[0]; // [RULE7]
                        end else begin
                            st = ST_BADVAL;
                        end
                    end else begin
                        st = ST_BADTYPE;
                    end
                end
                INSTR_INREAD: begin // [RULE8]
                    if (cmd_ff.bank == BANK_DIG
                        && cmd_ff.kind < 8'(NIN)) begin
                        rv = {31'h0, gpIn[cmd_ff.kind[1:0]]}; // [RULE12]
                    end else if (cmd_ff.bank == BANK_DIG
                                 && cmd_ff.kind == PORT_ALL) begin
                        rv = {24'h0, 8'(gpIn)};
                        accLoad = 1'b1; // [RULE14]
                    end else if (cmd_ff.bank == BANK_DIG
                                 && cmd_ff.kind == PORT_ENCZERO) begin
                        rv = {31'h0, encZero[0]}; // [RULE15]
                    end else if (cmd_ff.bank == BANK_ANA
                                 && cmd_ff.kind == PORT_ADC0) begin
                        rv = {20'h0, adcCount}; // [RULE9] [RULE13] [RULE16]
                    end else if (cmd_ff.bank == BANK_ANA
                                 && cmd_ff.kind == PORT_VSUPPLY) begin
                        rv = {16'h0, supplyTenthV}; // [RULE16]
                    end else if (cmd_ff.bank == BANK_ANA
                                 && cmd_ff.kind == PORT_TEMP) begin
                        rv = {16'h0, tempDegC}; // [RULE16]
                    end else if (cmd_ff.bank == BANK_OUT
                                 && cmd_ff.kind < 8'(NOUT)) begin
                        rv = {31'h0, gpOutput_ff[cmd_ff.kind[0]]}; // [RULE18]
                    end else if (cmd_ff.bank == BANK_OUT
                                 && cmd_ff.kind == PORT_ALL) begin
                        rv = {24'h0, 8'(gpOutput_ff)}; // [RULE17]
                    end else begin
                        st = ST_BADTYPE;
                    end
                    // standalone runs copy into accumulator
                    if (st == ST_OK && standalone_ff) begin
                        accLoad = 1'b1; // [RULE10]
                    end
                    // direct mode keeps it, except the all-inputs read
                    if (!standalone_ff && !(cmd_ff.bank == BANK_DIG
                        && cmd_ff.kind == PORT_ALL)) begin
                        accLoad = 1'b0; // [RULE11]
                    end
                    accVal = rv;
                end
                default: st = ST_BADCMD;
            endcase
        end
        if (st != ST_OK) begin
            nxt_gpOut  = gpOutput_ff;
            nxt_pullUp = pullUpEn_ff;
            nxt_hStart = 1'b0;
            nxt_hStop  = 1'b0;
            accLoad    = 1'b0;
        end
        // reply frame body
        repRaw = '{host: RST_HOST_ADDR, target: modAddr_ff, status: st,
                   instr: cmd_ff.instr, value: rv, sum: 8'h00}; // [RULE19]
    end

    ////////////////////////////////////////////////////////////////////////
    // bus and register next values
    always_comb begin
        nxt_aValid = hsel && hready && htrans[1];
        nxt_aWrite = hwrite;
        nxt_aAddr  = haddr;
        nxt_rdata  = rdata_ff;
        nxt_cmd    = cmd_ff;
        nxt_go     = 1'b0;
        nxt_rep    = rep_ff;
        nxt_repNew = repNew_ff;
        nxt_acc    = acc_ff;
        nxt_modAddr = modAddr_ff;
        nxt_standalone = standalone_ff;
        nxt_homeBusy = homeBusy_ff;
        // data phase of a write
        if (aValid_ff && aWrite_ff) begin
            unique case (aAddr_ff)
                A_TXFRAME0: nxt_cmd[71:40] = hwdata;
                A_TXFRAME1: nxt_cmd[39:8]  = hwdata;
                A_TXGO: begin
                    nxt_cmd.sum = hwdata[7:0];
                    nxt_go      = 1'b1;
                end
                A_ADDR:     nxt_modAddr    = hwdata[7:0];
                A_ACC:      nxt_acc        = hwdata;
                A_MODE:     nxt_standalone = hwdata[0];
                A_HOMEDONE: nxt_homeBusy   = nxt_homeBusy & ~hwdata[0];
                default: ;
            endcase
        end
        // frame execution after bus writes, so hardware updates win
        if (go_ff) begin
            nxt_rep     = repRaw;
            nxt_rep.sum = repSum; // [RULE20]
            nxt_repNew  = 1'b1;
            if (accLoad) begin
                nxt_acc = accVal;
            end
            if (nxt_hStart) begin
                nxt_homeBusy = 1'b1;
            end
            if (nxt_hStop) begin
                nxt_homeBusy = 1'b0;
            end
        end
        // reading the reply clears its flag, a new reply wins
        if (aValid_ff && !aWrite_ff && aAddr_ff == A_RXFRAME1 && !go_ff) begin
            nxt_repNew = 1'b0;
        end
        // read data is prepared during the address phase
        if (nxt_aValid && !hwrite) begin
            unique case (haddr)
                A_RXFRAME0: nxt_rdata = rep_ff[71:40];
                A_RXFRAME1: nxt_rdata = rep_ff[39:8];
                A_STATUS:   nxt_rdata = {8'h00, rep_ff.sum, 14'h0,
                                         homeBusy_ff, repNew_ff};
                A_ADDR:     nxt_rdata = {24'h0, modAddr_ff};
                A_ACC:      nxt_rdata = acc_ff;
                A_MODE:     nxt_rdata = {31'h0, standalone_ff};
                default:    nxt_rdata = 32'h0000_0000;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // registers
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            aValid_ff     <= 1'b0;
            aWrite_ff     <= 1'b0;
            aAddr_ff      <= 8'h00;
            rdata_ff      <= 32'h0000_0000;
            cmd_ff        <= '0;
            rep_ff        <= '0;
            go_ff         <= 1'b0;
            repNew_ff     <= 1'b0;
            standalone_ff <= 1'b0;
            acc_ff        <= 32'h0000_0000;
            modAddr_ff    <= RST_MODULE_ADDR;
            homeBusy_ff   <= 1'b0;
            gpOutput_ff   <= '0;
            pullUpEn_ff   <= 1'b0;
            homeStart_ff  <= 1'b0;
            homeStop_ff   <= 1'b0;
        end else begin
            aValid_ff     <= nxt_aValid;
            aWrite_ff     <= nxt_aWrite;
            aAddr_ff      <= nxt_aAddr;
            rdata_ff      <= nxt_rdata;
            cmd_ff        <= nxt_cmd;
            rep_ff        <= nxt_rep;
            go_ff         <= nxt_go;
            repNew_ff     <= nxt_repNew;
            standalone_ff <= nxt_standalone;
            acc_ff        <= nxt_acc;
            modAddr_ff    <= nxt_modAddr;
            homeBusy_ff   <= nxt_homeBusy;
            gpOutput_ff   <= go_ff ? nxt_gpOut : gpOutput_ff;
            pullUpEn_ff   <= go_ff ? nxt_pullUp : pullUpEn_ff;
            homeStart_ff  <= go_ff & nxt_hStart;
            homeStop_ff   <= go_ff & nxt_hStop;
        end
    end

    // zero-wait slave, always OKAY
    assign hrdata    = rdata_ff;
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;

    ////////////////////////////////////////////////////////////////////////
    // checks
    property p_start_busy;
        @(posedge clk) disable iff (!rst_n)
        homeStart_ff |-> homeBusy_ff;
    endproperty
    a_start_busy: assert property (p_start_busy) // [RULE1]
        else $error("homing start did not mark search busy");
    property p_stop_idle;
        @(posedge clk) disable iff (!rst_n)
        homeStop_ff |-> !homeBusy_ff;
    endproperty
    a_stop_idle: assert property (p_stop_idle) // [RULE2]
        else $error("homing stop left search busy");
    property p_reply_ok;
        @(posedge clk) disable iff (!rst_n)
        (go_ff && cmd_ff.sum == cmdSum && cmd_ff.instr == INSTR_HOMING
         && cmd_ff.kind == HOME_START) |=> rep_ff.status == ST_OK;
    endproperty
    a_reply_ok: assert property (p_reply_ok) // [RULE3]
        else $error("homing start reply not OK");
    property p_out_hold;
        @(posedge clk) disable iff (!rst_n)
        !go_ff |=> $stable(gpOutput_ff);
    endproperty
    a_out_hold: assert property (p_out_hold) // [RULE4]
        else $error("outputs changed without a command");
    property p_direct_acc;
        @(posedge clk) disable iff (!rst_n)
        (go_ff && !standalone_ff && cmd_ff.instr == INSTR_INREAD
         && !(cmd_ff.bank == BANK_DIG && cmd_ff.kind == PORT_ALL)
         && !(aValid_ff && aWrite_ff)) |=> $stable(acc_ff);
    endproperty
    a_direct_acc: assert property (p_direct_acc) // [RULE11]
        else $error("direct read changed accumulator");
    property p_rep_sum;
        @(posedge clk) disable iff (!rst_n)
        go_ff |=> rep_ff.sum == (rep_ff.host + rep_ff.target + rep_ff.status
            + rep_ff.instr + rep_ff.value[31:24] + rep_ff.value[23:16]
            + rep_ff.value[15:8] + rep_ff.value[7:0]);
    endproperty
    a_rep_sum: assert property (p_rep_sum) // [RULE20]
        else $error("reply checksum wrong");
    property p_rep_instr;
        @(posedge clk) disable iff (!rst_n)
        go_ff |=> rep_ff.instr == $past(cmd_ff.instr) && repNew_ff;
    endproperty
    a_rep_instr: assert property (p_rep_instr) // [RULE19]
        else $error("reply instruction mismatch");
    property p_bit_read;
        @(posedge clk) disable iff (!rst_n)
        (go_ff && st == ST_OK && cmd_ff.instr == INSTR_INREAD
         && cmd_ff.bank == BANK_DIG && cmd_ff.kind < 8'(NIN))
         |=> rep_ff.value[31:1] == 31'h0;
    endproperty
    a_bit_read: assert property (p_bit_read) // [RULE9]
        else $error("digital read not 0 or 1");
endmodule
`default_nettype wire

// >>> logic/hioc_pkg.sv
`default_nettype none
package hioc_pkg;
    // command codes
    localparam logic [7:0] INSTR_HOMING  = 8'h0D;
    localparam logic [7:0] INSTR_OUTSET  = 8'h0E;
    localparam logic [7:0] INSTR_INREAD  = 8'h0F;
    // homing types
    localparam logic [7:0] HOME_START    = 8'h00;
    localparam logic [7:0] HOME_STOP     = 8'h01;
    localparam logic [7:0] HOME_STATUS   = 8'h02;
    // banks and ports
    localparam logic [7:0] BANK_DIG      = 8'h00;
    localparam logic [7:0] BANK_ANA      = 8'h01;
    localparam logic [7:0] BANK_OUT      = 8'h02;
    localparam logic [7:0] PORT_ALL      = 8'hFF;
    localparam logic [7:0] PORT_ENCZERO  = 8'h0B;
    localparam logic [7:0] PORT_ADC0     = 8'h00;
    localparam logic [7:0] PORT_VSUPPLY  = 8'h08;
    localparam logic [7:0] PORT_TEMP     = 8'h09;
    localparam logic [7:0] PORT_PULLUP   = 8'h00;
    localparam logic [31:0] VAL_FROM_ACC = 32'hFFFFFFFF;
    // reply status codes
    localparam logic [7:0] ST_OK         = 8'h64;
    localparam logic [7:0] ST_BADSUM     = 8'h01;
    localparam logic [7:0] ST_BADCMD     = 8'h02;
    localparam logic [7:0] ST_BADTYPE    = 8'h03;
    localparam logic [7:0] ST_BADVAL     = 8'h04;
    // frame geometry
    localparam int FRAME_LEN             = 9;
    localparam logic [3:0] LAST_IDX      = 4'h8;
    // register map (word offsets, byte addresses)
    localparam logic [7:0] A_TXFRAME0    = 8'h00;
    localparam logic [7:0] A_TXFRAME1    = 8'h04;
    localparam logic [7:0] A_TXGO        = 8'h08;
    localparam logic [7:0] A_RXFRAME0    = 8'h0C;
    localparam logic [7:0] A_RXFRAME1    = 8'h10;
    localparam logic [7:0] A_STATUS      = 8'h14;
    localparam logic [7:0] A_ADDR        = 8'h18;
    localparam logic [7:0] A_ACC         = 8'h1C;
    localparam logic [7:0] A_MODE        = 8'h20;
    localparam logic [7:0] A_HOMEDONE    = 8'h24;
    localparam logic [7:0] RST_MODULE_ADDR = 8'h01;
    localparam logic [7:0] RST_HOST_ADDR   = 8'h02;

    // decoded command fields
    typedef struct packed {
        logic [7:0]  target;
        logic [7:0]  instr;
        logic [7:0]  kind;
        logic [7:0]  bank;
        logic [31:0] value;
        logic [7:0]  sum;
    } hioc_cmd_type;

    // reply fields
    typedef struct packed {
        logic [7:0]  host;
        logic [7:0]  target;
        logic [7:0]  status;
        logic [7:0]  instr;
        logic [31:0] value;
        logic [7:0]  sum;
    } hioc_rep_type;
endpackage
`default_nettype wire

// >>> logic/hioc_sum.sv
`timescale 1ns/1ps
`default_nettype none
// modulo-256 sum of the first eight bytes of a frame
module hioc_sum
    import hioc_pkg::*;
(
    // frame body
    input  wire logic [63:0] body,
    // resulting checksum
    output logic      [7:0]  sum
);
    // byte-wise accumulation, carries beyond bit 7 dropped
    always_comb begin
        sum = 8'h00;
        for (int i = 0; i < 8; i++) begin
            sum = sum + body[8*i +: 8]; // [RULE20]
        end
    end
endmodule
`default_nettype wire

// >>> logic/hioc_sync.sv
`timescale 1ns/1ps
`default_nettype none
// two-flop synchroniser for a bundle of pin levels
module hioc_sync
    import hioc_pkg::*;
#(
    parameter int W = 8
) (
    // clock and reset
    input  wire logic         clk,
    input  wire logic         rst_n,
    // pins and synchronised copy
    input  wire logic [W-1:0] din,
    output logic      [W-1:0] dout
);
    logic [W-1:0] meta_ff; // first stage, read only by the second
    logic [W-1:0] nxt_meta;
    logic [W-1:0] nxt_dout;
    // next-value logic
    always_comb begin
        nxt_meta = din;
        nxt_dout = meta_ff;
    end
    // registers
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            meta_ff <= '0;
            dout    <= '0;
        end else begin
            meta_ff <= nxt_meta;
            dout    <= nxt_dout;
        end
    end
endmodule
`default_nettype wire

// >>> sim/hioc_host_model.sv
`timescale 1ns/1ps
`default_nettype none
// host side: bus master and command framing
module hioc_host_model
    import hioc_pkg::*;
(
    // clock
    input  wire logic        clk,
    // bus request
    output logic             hsel,
    output logic [7:0]       haddr,
    output logic [1:0]       htrans,
    output logic             hwrite,
    output logic [2:0]       hsize,
    output logic [31:0]      hwdata,
    // bus answer
    input  wire logic        hready,
    input  wire logic [31:0] hrdata
);
    ////////////////////////////////////////////////////////////////////////
    // idle bus from time zero
    initial begin
        hsel   = 1'b0;
        haddr  = 8'h00;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize  = 3'h2;
        hwdata = 32'h0;
    end

    // modulo-256 sum of four bytes
    function automatic logic [7:0] bsum(input logic [31:0] w);
        return w[31:24] + w[23:16] + w[15:8] + w[7:0];
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // one single word transfer, held until hready is seen
    task automatic xfer(input logic wr, input logic [7:0] a,
                        input logic [31:0] d, output logic [31:0] q);
        @(posedge clk);
        hsel   <= 1'b1;
        haddr  <= a;
        hwrite <= wr;
        hsize  <= 3'h2;
        htrans <= 2'h2;
        do @(posedge clk); while (hready !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge clk); while (hready !== 1'b1);
        q = hrdata;
    endtask

    // sends one frame, polls for the reply; adj spoils the checksum
    task automatic send_cmd(input logic [7:0] ins, kind, bank,
        input logic [31:0] val, input logic [7:0] adj,
        output logic [31:0] head, output logic [31:0] rv,
        output logic [7:0] rs);
        logic [31:0] hw;
        logic [31:0] st;
        logic [31:0] dummy;
        hw   = {RST_MODULE_ADDR, ins, kind, bank};
        head = 32'hX;
        rv   = 32'hX;
        rs   = 8'hX;
        xfer(1'b1, A_TXFRAME0, hw, dummy);
        xfer(1'b1, A_TXFRAME1, val, dummy);
        xfer(1'b1, A_TXGO, {24'h0, bsum(hw) + bsum(val) + adj}, dummy);
        // bounded poll of the reply-new flag
        for (int i = 0; i < 20; i++) begin
            xfer(1'b0, A_STATUS, 32'h0, st);
            if (st[0] === 1'b1) break;
        end
        if (st[0] === 1'b1) begin
            rs = st[23:16];
            xfer(1'b0, A_RXFRAME0, 32'h0, head);
            xfer(1'b0, A_RXFRAME1, 32'h0, rv);
        end
    endtask
endmodule
`default_nettype wire

// >>> sim/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench
    import hioc_pkg::*;
;
    logic clk, rst_n, hsel, hwrite, hreadyOut, encZeroPin, pullUpEn;
    logic homeStart, homeStop, hresp;
    logic [7:0]  haddr;
    logic [1:0]  htrans, gpOutput;
    logic [2:0]  hsize;
    logic [31:0] hwdata, hrdata, repVal, d;
    logic [3:0]  gpInputPin;
    logic [11:0] adcCount;
    logic [15:0] supplyTenthV, tempDegC;
    int          errCount, compares, startCnt, stopCnt;

    hioc_cmd_handler u_dut (.clk(clk), .rst_n(rst_n), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hreadyOut), .hrdata(hrdata),
        .hreadyout(hreadyOut), .hresp(hresp), .gpInputPin(gpInputPin),
        .encZeroPin(encZeroPin), .gpOutput_ff(gpOutput),
        .pullUpEn_ff(pullUpEn), .adcCount(adcCount),
        .supplyTenthV(supplyTenthV), .tempDegC(tempDegC),
        .homeStart_ff(homeStart), .homeStop_ff(homeStop));
    hioc_host_model u_host (.clk(clk), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hreadyOut), .hrdata(hrdata));

    ////////////////////////////////////////////////////////////////////////
    // clock and homing pulse counters
    always #5 clk = ~clk;
    always @(posedge clk) begin
        if (homeStart === 1'b1) startCnt++;
        if (homeStop === 1'b1) stopCnt++;
    end

    // counted comparison
    task automatic check(input logic [31:0] got, exp, input string m);
        compares++;
        if (got !== exp) begin
            errCount++;
            $display("wrong value at %0t: %s", $time, m);
        end
    endtask

    // one command with reply checks
    task automatic run(input logic [7:0] ins, kind, bank,
        input logic [31:0] val, input logic [7:0] adj, expSt,
        input logic chkVal, input logic [31:0] expVal);
        logic [31:0] head;
        logic [7:0]  rs;
        u_host.send_cmd(ins, kind, bank, val, adj, head, repVal, rs);
        check(head, {RST_HOST_ADDR, RST_MODULE_ADDR, expSt, ins}, "head");
        check({24'h0, rs}, {24'h0, u_host.bsum(head) + u_host.bsum(repVal)},
              "reply sum");
        if (chkVal) check(repVal, expVal, "reply value");
    endtask

    task automatic report_and_stop;
        $display("compares %0d errCount %0d", compares, errCount);
        if (errCount == 0 && compares > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // watchdog
    initial begin
        #300000;
        errCount++;
        report_and_stop();
    end

    ////////////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        clk = 1'b0; rst_n = 1'b0; errCount = 0; compares = 0;
        startCnt = 0; stopCnt = 0; encZeroPin = 1'b0; gpInputPin = 4'h0;
        adcCount = 12'h0; supplyTenthV = 16'h0; tempDegC = 16'h0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        gpInputPin <= 4'hA; encZeroPin <= 1'b1; adcCount <= 12'hFFF;
        supplyTenthV <= 16'h00F0; tempDegC <= 16'h0019;
        u_host.xfer(1'b0, 8'h40, 32'h0, d);
        check(d, 32'h0, "unmapped read");
        check({31'h0, hresp}, 32'h0, "okay response");
        // homing start, query, stop, query, engine done
        run(INSTR_HOMING, HOME_START, 8'h00, 0, 0, ST_OK, 0, 0);
        check(startCnt, 1, "start pulse");
        run(INSTR_HOMING, HOME_STATUS, 8'h00, 0, 0, ST_OK, 0, 0);
        check({31'h0, repVal != 0}, 1, "busy query");
        run(INSTR_HOMING, HOME_STOP, 8'h00, 0, 0, ST_OK, 0, 0);
        check(stopCnt, 1, "stop pulse");
        run(INSTR_HOMING, HOME_STATUS, 8'h00, 0, 0, ST_OK, 1, 0);
        run(INSTR_HOMING, HOME_START, 8'h00, 0, 0, ST_OK, 0, 0);
        u_host.xfer(1'b1, A_HOMEDONE, 32'h1, d);
        run(INSTR_HOMING, HOME_STATUS, 8'h00, 0, 0, ST_OK, 1, 0);
        // single outputs set and read back
        for (logic [7:0] p = 8'h00; p < 8'h02; p++) begin
            run(INSTR_OUTSET, p, BANK_OUT, 1, 0, ST_OK, 0, 0);
            check({31'h0, gpOutput[p[0]]}, 1, "single out");
            run(INSTR_INREAD, p, BANK_OUT, 0, 0, ST_OK, 1, 1);
        end
        run(INSTR_OUTSET, PORT_ALL, BANK_OUT, 2, 0, ST_OK, 0, 0);
        check({30'h0, gpOutput}, 2, "all outs");
        run(INSTR_INREAD, 8'h00, BANK_OUT, 0, 0, ST_OK, 1, 0);
        u_host.xfer(1'b1, A_ACC, 32'h1, d);
        run(INSTR_OUTSET, PORT_ALL, BANK_OUT, VAL_FROM_ACC, 0, ST_OK, 0, 0);
        check({30'h0, gpOutput}, 1, "outs from acc");
        run(INSTR_OUTSET, PORT_ALL, BANK_OUT, 256, 0, ST_BADVAL, 0, 0);
        run(INSTR_OUTSET, 8'h00, BANK_OUT, 0, 1, ST_BADSUM, 0, 0);
        check({30'h0, gpOutput}, 1, "outs kept");
        // pull-ups on then off
        for (int v = 1; v >= 0; v--) begin
            run(INSTR_OUTSET, PORT_PULLUP, BANK_DIG, v, 0, ST_OK, 0, 0);
            check({31'h0, pullUpEn}, v, "pull-up");
        end
        // digital and analog reads
        for (logic [7:0] p = 8'h00; p < 8'h04; p++) begin
            run(INSTR_INREAD, p, BANK_DIG, 0, 0, ST_OK, 1,
                {31'h0, gpInputPin[p[1:0]]});
        end
        run(INSTR_INREAD, PORT_ENCZERO, BANK_DIG, 0, 0, ST_OK, 1, 1);
        u_host.xfer(1'b1, A_ACC, 32'h55, d);
        run(INSTR_INREAD, PORT_ADC0, BANK_ANA, 0, 0, ST_OK, 1, 4095);
        run(INSTR_INREAD, PORT_VSUPPLY, BANK_ANA, 0, 0, ST_OK, 1, 240);
        run(INSTR_INREAD, PORT_TEMP, BANK_ANA, 0, 0, ST_OK, 1, 25);
        u_host.xfer(1'b0, A_ACC, 32'h0, d);
        check(d, 32'h55, "acc direct");
        run(INSTR_INREAD, PORT_ALL, BANK_DIG, 0, 0, ST_OK, 0, 0);
        u_host.xfer(1'b0, A_ACC, 32'h0, d);
        check({24'h0, d[7:0]}, 32'h0A, "acc all inputs");
        u_host.xfer(1'b1, A_MODE, 32'h1, d);
        run(INSTR_INREAD, PORT_TEMP, BANK_ANA, 0, 0, ST_OK, 1, 25);
        u_host.xfer(1'b0, A_ACC, 32'h0, d);
        check(d, 32'h19, "acc standalone");
        report_and_stop();
    end
endmodule
`default_nettype wire
